/* verilog/rotate_consts.svh */
// Constants for the rotate instruction unit: offsets, fields, opcodes, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef ROTATE_CONSTS_SVH
`define ROTATE_CONSTS_SVH
// Register byte offsets (word aligned)
`define OFF_INSTR 8'h00
`define OFF_CTRL 8'h04
`define OFF_WREG 8'h08
`define OFF_STAT 8'h0C
`define OFF_FSR2 8'h10
// Control register fields
`define CTRL_BSR_HI 3
`define CTRL_EXT_BIT 8
// Status register fields
`define STAT_C_BIT 0
`define STAT_Z_BIT 1
`define STAT_N_BIT 2
`define STAT_BUSY_BIT 8
`define STAT_ILL_BIT 9
// Instruction word fields and fixed opcode bits
`define OPC_HI 15
`define OPC_LO 10
`define DEST_BIT 9
`define ACC_BIT 8
`define OPC_ROT_LEFT_PLAIN 6'h11
`define OPC_ROT_RIGHT_CARRY 6'h0C
// Addressing
`define IDX_LIMIT 8'h5F
`define ACC_SPLIT 8'h60
`define ACC_HIGH_BANK 4'hF
`define ACC_LOW_BANK 4'h0
// Reset values
`define RST_INSTR 16'h0000
`define RST_BYTE 8'h00
`define RST_BSR 4'h0
`define RST_FSR2 12'h000
`define AHB_OKAY 1'b0
`endif

/* verilog/rotate_pkg.sv */
// Types for the rotate instruction unit.
// Assumes nothing beyond a SystemVerilog compiler.
package rotate_pkg;
	// Instruction cycle phases, Gray coded
	typedef enum logic [1:0] {
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b11,
		Q4 = 2'b10
	} q_phase_t;
	// Decoded operation
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ROT_LEFT_PLAIN = 2'b01,
		OP_ROT_RIGHT_CARRY = 2'b10
	} rot_op_t;
endpackage

/* verilog/rotate_instruction_unit.sv */
// Rotate instruction unit: left rotate without carry and right rotate through carry,
// with an AHB-Lite register slave and a file register memory port.
// Assumes the file memory returns file_rdata combinationally from file_addr, same clock.
// Behaviour
// - decode left plain rotate, opcode 010001
// - left rotate, bit7 into bit0, N Z
// - decode right carry rotate, opcode 001100
// - right rotate via carry, C N Z updated
// - dest 0 to working reg, 1 file
// - access bit 0 access bank, 1 bank select
// - extended mode, f up to 5Fh indexed
// - one word, four phases, write in Q4
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "rotate_consts.svh"
module rotate_instruction_unit
	import rotate_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [11:0] file_addr,
	input wire logic [7:0] file_rdata,
	output logic [7:0] file_wdata,
	output logic file_we
);
	logic [7:0] addr_q;
	logic wr_q;
	logic [31:0] hrdata_q;
	logic [15:0] instr_q;
	logic [3:0] bsr_q;
	logic ext_q;
	logic [11:0] fsr2_q;
	logic [7:0] w_q;
	logic c_q, z_q, n_q;
	logic busy_q, ill_q;
	q_phase_t phase_q;
	rot_op_t op_q;
	logic dest_q;
	logic [7:0] operand_q, result_q;
	logic carry_new_q;
	logic [11:0] file_addr_q;
	logic [7:0] file_wdata_q;
	logic file_we_q;
	logic addr_ph, st_wr, start;
	logic [7:0] f_field;
	rot_op_t op_d;
	logic [11:0] ea_d;
	logic commit;

	// Bus address phase acceptance and data phase writes
	assign addr_ph = hsel && htrans[1] && hready;
	assign st_wr = wr_q && (addr_q == `OFF_STAT);
	assign start = wr_q && (addr_q == `OFF_INSTR) && !busy_q;
	assign commit = ce && busy_q && (phase_q == Q4);
	assign f_field = instr_q[7:0];

	// Opcode decode in Q1
	always_comb begin
		unique case (instr_q[`OPC_HI:`OPC_LO])
			`OPC_ROT_LEFT_PLAIN: op_d = OP_ROT_LEFT_PLAIN;
			`OPC_ROT_RIGHT_CARRY: op_d = OP_ROT_RIGHT_CARRY;
			default: op_d = OP_NONE;
		endcase
	end

	// Effective file address: bank select, indexed literal offset or access bank
	always_comb begin
		if (instr_q[`ACC_BIT]) begin
			ea_d = {bsr_q, f_field};
		end else if (ext_q && (f_field <= `IDX_LIMIT)) begin
			ea_d = 12'(fsr2_q + {4'h0, f_field});
		end else if (f_field < `ACC_SPLIT) begin
			ea_d = {`ACC_LOW_BANK, f_field};
		end else begin
			ea_d = {`ACC_HIGH_BANK, f_field};
		end
	end

	// AHB-Lite slave: latch address phase, answer with zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= `RST_BYTE;
			wr_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else if (ce) begin
			wr_q <= addr_ph && hwrite;
			if (addr_ph) begin
				addr_q <= haddr[7:0];
			end
			if (addr_ph && !hwrite) begin
				unique case (haddr[7:0])
					`OFF_INSTR: hrdata_q <= {16'h0000, instr_q};
					`OFF_CTRL: hrdata_q <= {23'h0, ext_q, 4'h0, bsr_q};
					`OFF_WREG: hrdata_q <= {24'h0, w_q};
					`OFF_STAT: hrdata_q <= {22'h0, ill_q, busy_q, 5'h0, n_q, z_q, c_q};
					`OFF_FSR2: hrdata_q <= {20'h0, fsr2_q};
					default: hrdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers written by software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bsr_q <= `RST_BSR;
			ext_q <= 1'b0;
			fsr2_q <= `RST_FSR2;
			instr_q <= `RST_INSTR;
		end else if (ce) begin
			if (wr_q && addr_q == `OFF_CTRL) begin
				bsr_q <= hwdata[`CTRL_BSR_HI:0];
				ext_q <= hwdata[`CTRL_EXT_BIT];
			end
			if (wr_q && addr_q == `OFF_FSR2) begin
				fsr2_q <= hwdata[11:0];
			end
			if (start) begin
				instr_q <= hwdata[15:0];
			end
		end
	end

	// Instruction cycle sequencer: Q1 decode, Q2 read, Q3 process, Q4 write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			ill_q <= 1'b0;
			phase_q <= Q1;
			op_q <= OP_NONE;
			dest_q <= 1'b1;
		end else if (ce) begin
			if (start) begin
				busy_q <= 1'b1;
				phase_q <= Q1;
				ill_q <= 1'b0;
			end else if (busy_q) begin
				unique case (phase_q)
					Q1: begin
						op_q <= op_d;
						dest_q <= instr_q[`DEST_BIT];
						if (op_d == OP_NONE) begin
							busy_q <= 1'b0;
							ill_q <= 1'b1;
						end else begin
							phase_q <= Q2;
						end
					end
					Q2: phase_q <= Q3;
					Q3: phase_q <= Q4;
					Q4: begin
						phase_q <= Q1;
						busy_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Datapath: address in Q1, operand in Q2, rotate in Q3
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			file_addr_q <= 12'h000;
			operand_q <= `RST_BYTE;
			result_q <= `RST_BYTE;
			carry_new_q <= 1'b0;
		end else if (ce && busy_q) begin
			if (phase_q == Q1) begin
				file_addr_q <= ea_d;
			end
			if (phase_q == Q2) begin
				operand_q <= file_rdata;
			end
			if (phase_q == Q3) begin
				if (op_q == OP_ROT_LEFT_PLAIN) begin
					result_q <= {operand_q[6:0], operand_q[7]};
					carry_new_q <= c_q;
				end else begin
					result_q <= {c_q, operand_q[7:1]};
					carry_new_q <= operand_q[0];
				end
			end
		end
	end

	// Q4 write-back to file register or working register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			file_we_q <= 1'b0;
			file_wdata_q <= `RST_BYTE;
			w_q <= `RST_BYTE;
		end else if (ce) begin
			file_we_q <= commit && dest_q;
			if (commit && dest_q) begin
				file_wdata_q <= result_q;
			end
			if (commit && !dest_q) begin
				w_q <= result_q;
			end else if (wr_q && addr_q == `OFF_WREG) begin
				w_q <= hwdata[7:0];
			end
		end
	end

	// Status flags; hardware update wins over a same-cycle software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			c_q <= 1'b0;
			z_q <= 1'b0;
			n_q <= 1'b0;
		end else if (ce) begin
			if (commit) begin
				z_q <= (result_q == `RST_BYTE);
				n_q <= result_q[7];
				if (op_q == OP_ROT_RIGHT_CARRY) begin
					c_q <= carry_new_q;
				end else if (st_wr) begin
					c_q <= hwdata[`STAT_C_BIT];
				end
			end else if (st_wr) begin
				c_q <= hwdata[`STAT_C_BIT];
				z_q <= hwdata[`STAT_Z_BIT];
				n_q <= hwdata[`STAT_N_BIT];
			end
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = `AHB_OKAY;
	assign file_addr = file_addr_q;
	assign file_wdata = file_wdata_q;
	assign file_we = file_we_q;

	// Checks
	phase_walk_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q2 |=> phase_q == Q3 && busy_q)
		else $error("phase did not advance from Q2 to Q3");
	done_q4_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit |=> !busy_q && phase_q == Q1)
		else $error("instruction not finished after Q4");
	decode_bad_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q1 && op_d == OP_NONE |=> !busy_q && ill_q)
		else $error("illegal opcode not refused");
	left_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q3 && op_q == OP_ROT_LEFT_PLAIN
		|=> result_q == {$past(operand_q[6:0]), $past(operand_q[7])})
		else $error("left rotate result wrong");
	right_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q3 && op_q == OP_ROT_RIGHT_CARRY
		|=> result_q == {$past(c_q), $past(operand_q[7:1])} && carry_new_q == $past(operand_q[0]))
		else $error("right rotate result or carry wrong");
	dest_file_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && dest_q |=> file_we_q && file_wdata_q == $past(result_q))
		else $error("file write-back missing");
	dest_w_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && !dest_q |=> !file_we_q && w_q == $past(result_q))
		else $error("working register write-back missing");
	flags_nz_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit |=> z_q == ($past(result_q) == 8'h00) && n_q == $past(result_q[7]))
		else $error("zero or negative flag wrong");
	left_carry_a: assert property (@(posedge hclk) disable iff (!hresetn)
		commit && op_q == OP_ROT_LEFT_PLAIN && !st_wr |=> c_q == $past(c_q))
		else $error("left plain rotate changed carry");
	bank_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q1 && instr_q[`ACC_BIT] |=> file_addr_q == $past({bsr_q, f_field}))
		else $error("bank select address wrong");
	indexed_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && busy_q && phase_q == Q1 && !instr_q[`ACC_BIT] && ext_q && f_field <= `IDX_LIMIT
		|=> file_addr_q == $past(fsr2_q + {4'h0, f_field}))
		else $error("indexed literal offset address wrong");
endmodule

/* dv/file_mem_model.sv */
// File register memory model for the rotate unit's file port.
// Assumes the unit reads combinationally and writes on a one-cycle strobe.
`timescale 1ns/1ps
module file_mem_model (
	input wire logic hclk,
	input wire logic [11:0] file_addr,
	input wire logic [7:0] file_wdata,
	input wire logic file_we,
	output logic [7:0] file_rdata
);
	logic [7:0] mem [0:4095];
	// Preset contents from the address, so neighbouring bytes differ
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i * 37 + (i >> 4));
		end
	end
	// Read follows the address at once
	assign file_rdata = mem[file_addr];
	// Write-back on the strobe
	always @(posedge hclk) begin
		if (file_we === 1'b1) begin
			mem[file_addr] <= file_wdata;
		end
	end
endmodule

/* dv/test_rotate_instruction_unit.sv */
// Testbench: random rotates started over the register bus, reads and file writes checked.
// Assumes the unit, its constants header and the file memory model.
`timescale 1ns/1ps
`include "rotate_consts.svh"
module test_rotate_instruction_unit;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, chk = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h0000C7F3, hrdata, r, rv, ew;
	logic [1:0] htrans = 2'b00;
	logic hreadyout, hresp, file_we, d, a, ext, c, nc, ok;
	logic [11:0] file_addr, fa, fs;
	logic [7:0] file_rdata, file_wdata, f, w, res, ref_mem [0:4095];
	logic [31:0] q_rd [$];
	logic [19:0] q_wr [$];
	logic [3:0] bank_select_register;
	logic [2:0] st;
	logic [5:0] opc;
	int fails = 0, n_checks = 0, k;
	always #4 hclk = ~hclk;
	rotate_instruction_unit i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
		.file_we(file_we));
	file_mem_model i_mem (.hclk(hclk), .file_addr(file_addr), .file_wdata(file_wdata),
		.file_we(file_we), .file_rdata(file_rdata));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One single word transfer; waits are bounded
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
		input logic ck, output logic [31:0] rd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, ad};
		hwrite <= wr;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		chk <= ck;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		chk <= 1'b0;
		if (n >= 50) begin
			fails++;
			close_out();
		end
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
		logic [31:0] v;
		q_rd.push_back(e);
		bus(1'b0, ad, 32'h0, 1'b1, v);
	endtask
	// Oldest note against each checked read and each file write
	always @(posedge hclk) begin
		if (chk === 1'b1 && hreadyout === 1'b1) begin
			cmp("read", q_rd.size() > 0 ? q_rd.pop_front() : 32'hFFFFFFFF, hrdata);
			cmp("hresp", {31'h0, `AHB_OKAY}, {31'h0, hresp});
		end
		if (file_we === 1'b1) begin
			ew = q_wr.size() > 0 ? 32'(q_wr.pop_front()) : 32'hFFFFFFFF;
			cmp("fwrite", ew, {12'h0, file_addr, file_wdata});
		end
	end
	initial begin
		for (k = 0; k < 4096; k++) begin
			ref_mem[k] = 8'(k * 37 + (k >> 4));
		end
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 8'h20, 32'hFFFFFFFF, 1'b0, rv);
		// Reset values, then unmapped places
		for (k = 0; k < 9; k++) begin
			rdc(8'(k * 4), 32'h0);
		end
		$display("test reset done");
		for (int t = 0; t < 40; t++) begin
			r = rnd();
			rv = rnd();
			{ext, bank_select_register, c, a, d} = r[7:0];
			f = r[31] ? (r[8] ? 8'h5F : 8'h60) : r[16:9];
			fs = r[28:17];
			w = rv[7:0];
			st = {rv[11:10], c};
			opc = rv[9:8] == 2'b11 ? 6'h3F : (rv[8] ? `OPC_ROT_RIGHT_CARRY : `OPC_ROT_LEFT_PLAIN);
			ok = opc != 6'h3F;
			if (a) fa = {bank_select_register, f};
			else if (ext && f <= `IDX_LIMIT) fa = fs + {4'h0, f};
			else fa = {f < `ACC_SPLIT ? `ACC_LOW_BANK : `ACC_HIGH_BANK, f};
			res = opc == `OPC_ROT_LEFT_PLAIN ? {ref_mem[fa][6:0], ref_mem[fa][7]} : {c, ref_mem[fa][7:1]};
			nc = opc == `OPC_ROT_LEFT_PLAIN ? c : ref_mem[fa][0];
			bus(1'b1, `OFF_CTRL, {23'h0, ext, 4'h0, bank_select_register}, 1'b0, rv);
			bus(1'b1, `OFF_WREG, {24'h0, w}, 1'b0, rv);
			bus(1'b1, `OFF_STAT, {29'h0, st}, 1'b0, rv);
			bus(1'b1, `OFF_FSR2, {20'h0, fs}, 1'b0, rv);
			if (ok && d) begin
				q_wr.push_back({fa, res});
				ref_mem[fa] = res;
			end
			bus(1'b1, `OFF_INSTR, {16'h0, opc, d, a, f}, 1'b0, rv);
			// A second start while busy must be ignored
			if (ok) bus(1'b1, `OFF_INSTR, {16'h0, `OPC_ROT_LEFT_PLAIN, 2'b11, ~f}, 1'b0, rv);
			k = 0;
			do begin
				bus(1'b0, `OFF_STAT, 32'h0, 1'b0, rv);
				k++;
			end while (rv[`STAT_BUSY_BIT] !== 1'b0 && k < 20);
			if (k >= 20) begin
				fails++;
				close_out();
			end
			if (ok) cmp("polls", 32'h2, 32'(k));
			rdc(`OFF_WREG, {24'h0, ok && !d ? res : w});
			rdc(`OFF_STAT, ok ? {29'h0, res[7], res == 8'h00, nc} : {22'h0, 2'b10, 5'h0, st});
			// The refused second start must leave the first instruction in place
			rdc(`OFF_INSTR, {16'h0, opc, d, a, f});
			rdc(`OFF_CTRL, {23'h0, ext, 4'h0, bank_select_register});
			rdc(`OFF_FSR2, {20'h0, fs});
			$display("test %0d done", t);
		end
		close_out();
	end
endmodule
